// ==== hdl/ccr_pkg.sv ====
// Package: offsets, field positions, reset values and modes of the card and device control registers
package ccr_pkg;
   // Offsets 0x91/0x92 are not multiples of four: they are register indices, byte address = 4 * index
   localparam logic [7:0] CCR_IDX_CARD = 8'h91;
   localparam logic [7:0] CCR_IDX_DEV = 8'h92;
   localparam logic [7:0] CCR_IDX_IRQ_STAT = 8'ha0;
   localparam logic [7:0] CCR_IDX_IRQ_MASK = 8'ha1;
   localparam logic [7:0] CCR_IDX_SYS = 8'ha2;
   localparam int CCR_ADDR_W = 12;
   localparam logic [CCR_ADDR_W-1:0] CCR_ADDR_CARD = {2'b00, CCR_IDX_CARD, 2'b00};
   localparam logic [CCR_ADDR_W-1:0] CCR_ADDR_DEV = {2'b00, CCR_IDX_DEV, 2'b00};
   localparam logic [CCR_ADDR_W-1:0] CCR_ADDR_IRQ_STAT = {2'b00, CCR_IDX_IRQ_STAT, 2'b00};
   localparam logic [CCR_ADDR_W-1:0] CCR_ADDR_IRQ_MASK = {2'b00, CCR_IDX_IRQ_MASK, 2'b00};
   localparam logic [CCR_ADDR_W-1:0] CCR_ADDR_SYS = {2'b00, CCR_IDX_SYS, 2'b00};

   // Card routing control fields
   localparam int CCR_CARD_RING_EN = 7;
   localparam int CCR_CARD_ZV_EN = 6;
   localparam int CCR_CARD_SPARE = 5;
   localparam int CCR_CARD_AUD_MUX = 2;
   localparam int CCR_CARD_SPKR_EN = 1;
   localparam int CCR_CARD_IRQ_FLAG = 0;
   localparam logic [7:0] CCR_CARD_RESET = 8'h00;
   localparam logic [7:0] CCR_CARD_WMASK = 8'he6;

   // Socket device control fields
   localparam int CCR_DEV_PWR_LOCK = 7;
   localparam int CCR_DEV_3V_FORCE = 6;
   localparam int CCR_DEV_DIAG5 = 5;
   localparam int CCR_DEV_TEST3 = 3;
   localparam int CCR_DEV_MODE_HI = 2;
   localparam int CCR_DEV_MODE_LO = 1;
   localparam int CCR_DEV_TEST0 = 0;
   localparam logic [7:0] CCR_DEV_RESET = 8'h66;
   localparam logic [7:0] CCR_DEV_WMASK = 8'hef;

   // Own status/mask and system bits
   localparam int CCR_IRQ_W = 1;
   localparam int CCR_SYS_RING_MUX = 0;
   localparam logic [7:0] CCR_SYS_RESET = 8'h00;

   typedef enum logic [1:0] {
      CCR_MODE_PAR_PCI = 2'b00,
      CCR_MODE_PAR_IRQ_PAR_PCI = 2'b01,
      CCR_MODE_SER_IRQ_PAR_PCI = 2'b10,
      CCR_MODE_SER_ALL = 2'b11
   } ccr_mode_e;
endpackage : ccr_pkg

// ==== hdl/ccr_regs.sv ====
// Card routing control and socket device control registers behind an APB slave
//
// How it works
// RULE1: Ring enable bit 7 clear blocks ring output everywhere; resets clear.
// RULE2: Ring enable set routes ring to ring/PME when mux zero, and terminals 2, 4.
// RULE3: Zoomed-video enable bit 6 tri-states the socket video terminals; resets zero.
// RULE4: Card bit 5 is plain read/write storage without effect.
// RULE5: Card bits 4 and 3 are read-only zero.
// RULE6: Audio mux bit 2 routes card audio to the audio PWM terminal.
// RULE7: Speaker enable bit 1 routes speaker; terminal drives only while set.
// RULE8: Card functional interrupt sets flag bit 0; resets zero.
// RULE9: Writing one to bit 0 clears the card interrupt flag.
// RULE10: Power lock bit 7 set ignores socket power-down in D3.
// RULE11: Device bit 6 forces reported 3-V capability; resets to one.
// RULE12: Device bit 5 is read/write diagnostic, resets to one.
// RULE13: Device bit 4 is read-only zero.
// RULE14: Software writes only zero to device test bit 3.
// RULE15: Mode field bits 2:1 selects interrupt signalling; resets to 11.
// RULE16: Device bit 0 is test, kept read/write; software writes zero.
// RULE17: Writing zero leaves flag; simultaneous interrupt beats the clear.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs
   import ccr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ccr_pkg::CCR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic card_func_irq,
   input wire logic ring_indicate_in,
   input wire logic card_audio_in,
   input wire logic card_speaker_in,
   input wire logic d3_power_down_req,
   output logic ring_pme_out,
   output logic multipurpose_terminal_2,
   output logic multipurpose_terminal_4,
   output logic card_audio_pwm_function,
   output logic speaker_output_terminal,
   output logic speaker_output_terminal_oe,
   output logic zoomed_video_oe,
   output logic socket_power_down,
   output logic three_volt_capable,
   output ccr_pkg::ccr_mode_e interrupt_signal_mode
);
   import ccr_pkg::*;

   logic [7:0] card_r;
   logic [7:0] dev_r;
   logic [7:0] sys_r;
   logic [CCR_IRQ_W-1:0] irq_stat_r;
   logic [CCR_IRQ_W-1:0] irq_mask_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic flag_clr;
   logic stat_rd;
   logic ring_enable;
   logic ring_mux_select;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign rd_en = psel & penable & ~pwrite;
   assign mapped = (paddr == CCR_ADDR_CARD) | (paddr == CCR_ADDR_DEV) | (paddr == CCR_ADDR_IRQ_STAT) |
                   (paddr == CCR_ADDR_IRQ_MASK) | (paddr == CCR_ADDR_SYS);
   assign flag_clr = wr_en & (paddr == CCR_ADDR_CARD) & pwdata[CCR_CARD_IRQ_FLAG]; // RULE9
   assign stat_rd = rd_en & (paddr == CCR_ADDR_IRQ_STAT);

   // Card control: bits 4:3 never stored, so they read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         card_r <= CCR_CARD_RESET; // RULE1 RULE3 RULE7 RULE8
      end else begin
         if (wr_en && paddr == CCR_ADDR_CARD) begin
            card_r[7:1] <= pwdata[7:1] & CCR_CARD_WMASK[7:1]; // RULE4 RULE5
         end
         // Set wins over clear so no interrupt is lost
         if (card_func_irq) begin
            card_r[CCR_CARD_IRQ_FLAG] <= 1'b1; // RULE8 RULE17
         end else if (flag_clr) begin
            card_r[CCR_CARD_IRQ_FLAG] <= 1'b0; // RULE9 RULE17
         end
      end
   end

   // Device control: bit 4 masked to zero, test bits kept as written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_r <= CCR_DEV_RESET; // RULE11 RULE12 RULE15
      end else if (wr_en && paddr == CCR_ADDR_DEV) begin
         dev_r <= pwdata[7:0] & CCR_DEV_WMASK; // RULE13 RULE16
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_r <= CCR_SYS_RESET;
      end else if (wr_en && paddr == CCR_ADDR_SYS) begin
         sys_r <= {7'h00, pwdata[CCR_SYS_RING_MUX]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= '0;
      end else if (wr_en && paddr == CCR_ADDR_IRQ_MASK) begin
         irq_mask_r <= pwdata[CCR_IRQ_W-1:0];
      end
   end

   // Sticky status, cleared by reading it; a new event in the read cycle stays set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= '0;
      end else if (card_func_irq) begin
         irq_stat_r <= 1'b1;
      end else if (stat_rd) begin
         irq_stat_r <= '0;
      end
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= psel & ~penable & ~mapped;
         if (psel && !penable && !pwrite) begin
            unique case (1'b1)
               paddr == CCR_ADDR_CARD: prdata_r <= {24'h000000, card_r};
               paddr == CCR_ADDR_DEV: prdata_r <= {24'h000000, dev_r};
               paddr == CCR_ADDR_IRQ_STAT: prdata_r <= {31'h00000000, irq_stat_r};
               paddr == CCR_ADDR_IRQ_MASK: prdata_r <= {31'h00000000, irq_mask_r};
               paddr == CCR_ADDR_SYS: prdata_r <= {24'h000000, sys_r};
               default: prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // Routing, combinational from register bits
   assign ring_enable = card_r[CCR_CARD_RING_EN];
   assign ring_mux_select = sys_r[CCR_SYS_RING_MUX];
   assign ring_pme_out = ring_enable & ~ring_mux_select & ring_indicate_in; // RULE1 RULE2
   assign multipurpose_terminal_2 = ring_enable & ring_indicate_in; // RULE1 RULE2
   assign multipurpose_terminal_4 = ring_enable & ring_indicate_in; // RULE1 RULE2
   assign card_audio_pwm_function = card_r[CCR_CARD_AUD_MUX] & card_audio_in; // RULE6
   assign speaker_output_terminal = card_r[CCR_CARD_SPKR_EN] & card_speaker_in; // RULE7
   assign speaker_output_terminal_oe = card_r[CCR_CARD_SPKR_EN]; // RULE7
   assign zoomed_video_oe = ~card_r[CCR_CARD_ZV_EN]; // RULE3
   // Lock only blocks the power-down; the request itself is external
   assign socket_power_down = d3_power_down_req & ~dev_r[CCR_DEV_PWR_LOCK]; // RULE10
   assign three_volt_capable = dev_r[CCR_DEV_3V_FORCE]; // RULE11
   assign interrupt_signal_mode = ccr_mode_e'(dev_r[CCR_DEV_MODE_HI:CCR_DEV_MODE_LO]); // RULE15

endmodule : ccr_regs
`default_nettype wire

// ==== tb/ccr_regs_properties.sv ====
// Concurrent checks on the card and device control register block
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_checker
   import ccr_pkg::*;
(
   input wire logic pclk, input wire logic presetn, input wire logic psel, input wire logic penable,
   input wire logic pwrite, input wire logic [ccr_pkg::CCR_ADDR_W-1:0] paddr, input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb, input wire logic [31:0] prdata, input wire logic ring_indicate_in,
   input wire logic card_audio_in, input wire logic card_speaker_in, input wire logic d3_power_down_req,
   input wire logic ring_pme_out, input wire logic multipurpose_terminal_2, input wire logic multipurpose_terminal_4,
   input wire logic card_audio_pwm_function, input wire logic speaker_output_terminal,
   input wire logic speaker_output_terminal_oe, input wire logic zoomed_video_oe, input wire logic socket_power_down,
   input wire logic three_volt_capable, input wire ccr_pkg::ccr_mode_e interrupt_signal_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Write lands only at the access edge with the low byte strobed
   wire logic wr_card = psel && penable && pwrite && pstrb[0] && paddr == CCR_ADDR_CARD;
   wire logic wr_dev = psel && penable && pwrite && pstrb[0] && paddr == CCR_ADDR_DEV;
   a_ring_source: assert property (multipurpose_terminal_2 |-> ring_indicate_in && multipurpose_terminal_4)
      else $error("ring terminal driven without source");
   a_pme_subset: assert property (ring_pme_out |-> multipurpose_terminal_2)
      else $error("ring/PME routed while terminals blocked");
   a_zv_write: assert property (wr_card |=> zoomed_video_oe == !$past(pwdata[6]))
      else $error("video tri-state does not follow write");
   a_card_rsvd: assert property (psel && penable && !pwrite && paddr == CCR_ADDR_CARD |-> prdata[4:3] == 2'b00)
      else $error("card reserved bits read nonzero");
   a_audio_gate: assert property (card_audio_pwm_function |-> card_audio_in)
      else $error("audio terminal without audio source");
   a_spkr_drive: assert property (speaker_output_terminal |-> speaker_output_terminal_oe && card_speaker_in)
      else $error("speaker driven while disabled");
   a_power_lock: assert property (socket_power_down |-> d3_power_down_req)
      else $error("socket powered down without request");
   a_mode_write: assert property (
      wr_dev |=> {three_volt_capable, interrupt_signal_mode} == {$past(pwdata[6]), $past(pwdata[2:1])})
      else $error("mode or 3V force does not follow write");
   a_lock_hold: assert property (wr_dev && pwdata[7] |=> !socket_power_down)
      else $error("socket powered down while lock set");
   a_ring_block: assert property (
      wr_card && !pwdata[7] |=> !(ring_pme_out | multipurpose_terminal_2 | multipurpose_terminal_4))
      else $error("ring routed after enable cleared");
   a_audio_off: assert property (wr_card && !pwdata[2] |=> !card_audio_pwm_function)
      else $error("audio routed after mux bit cleared");
   a_dev_rsvd: assert property (psel && penable && !pwrite && paddr == CCR_ADDR_DEV |-> !prdata[4])
      else $error("device reserved bit reads nonzero");
endmodule : ccr_regs_checker
bind ccr_regs ccr_regs_checker ccr_regs_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .ring_indicate_in(ring_indicate_in),
   .card_audio_in(card_audio_in), .card_speaker_in(card_speaker_in), .d3_power_down_req(d3_power_down_req),
   .ring_pme_out(ring_pme_out), .multipurpose_terminal_2(multipurpose_terminal_2),
   .multipurpose_terminal_4(multipurpose_terminal_4), .card_audio_pwm_function(card_audio_pwm_function),
   .speaker_output_terminal(speaker_output_terminal), .speaker_output_terminal_oe(speaker_output_terminal_oe),
   .zoomed_video_oe(zoomed_video_oe), .socket_power_down(socket_power_down), .three_volt_capable(three_volt_capable),
   .interrupt_signal_mode(interrupt_signal_mode));
`default_nettype wire

// ==== tb/ccr_regs_test.sv ====
// Self-checking bench for the card and device control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module ccr_regs_test;
   import ccr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [CCR_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic card_func_irq = 0, ring_indicate_in = 0, card_audio_in = 0, card_speaker_in = 0, d3_power_down_req = 0;
   logic pready, pslverr, irq, ring_pme_out, mp2, mp4, aud, spk, spk_oe, zv_oe, pwr_dn, cap3v;
   ccr_mode_e mode;
   int miscompares = 0, n_compared = 0;
   ccr_regs ccr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .card_func_irq(card_func_irq), .ring_indicate_in(ring_indicate_in), .card_audio_in(card_audio_in),
      .card_speaker_in(card_speaker_in), .d3_power_down_req(d3_power_down_req), .ring_pme_out(ring_pme_out),
      .multipurpose_terminal_2(mp2), .multipurpose_terminal_4(mp4), .card_audio_pwm_function(aud),
      .speaker_output_terminal(spk), .speaker_output_terminal_oe(spk_oe), .zoomed_video_oe(zv_oe),
      .socket_power_down(pwr_dn), .three_volt_capable(cap3v), .interrupt_signal_mode(mode));
   initial begin
      forever #25 pclk = ~pclk;
   end
   task automatic conclude();
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // Zero-wait slave, but the wait loop keeps the master honest
   task automatic apb(input logic w, input logic [CCR_ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string nm, input logic [CCR_ADDR_W-1:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK(nm, {24'h0, e}, rd)
   endtask : rchk
   initial begin
      #100us miscompares++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk("card reset", CCR_ADDR_CARD, 8'h00);
      rchk("dev reset", CCR_ADDR_DEV, 8'h66);
      `CHK("reset outs", {cap3v, zv_oe, spk_oe, mode}, 5'b11011)
      {ring_indicate_in, card_audio_in, card_speaker_in, d3_power_down_req} <= 4'hf;
      apb(1'b1, CCR_ADDR_CARD, 8'hfe);
      rchk("card rw", CCR_ADDR_CARD, 8'he6);
      `CHK("routes on", {ring_pme_out, mp2, mp4, aud, spk, spk_oe, zv_oe}, 7'b1111110)
      apb(1'b1, CCR_ADDR_SYS, 8'h01);
      @(negedge pclk);
      `CHK("ring mux", {ring_pme_out, mp2}, 2'b01)
      apb(1'b1, CCR_ADDR_CARD, 8'h00);
      @(negedge pclk);
      `CHK("routes off", {ring_pme_out, mp2, mp4, aud, spk, spk_oe, zv_oe}, 7'b0000001)
      // Test bits 3 and 0 always written as zero
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, CCR_ADDR_DEV, {m[0], 1'b0, m[1], 1'b1, 1'b0, m[1:0], 1'b0});
         rchk("dev rw", CCR_ADDR_DEV, {m[0], 1'b0, m[1], 2'b00, m[1:0], 1'b0});
         `CHK("dev outs", {pwr_dn, cap3v, mode}, {~m[0], 1'b0, m[1:0]})
      end
      apb(1'b1, CCR_ADDR_IRQ_MASK, 8'h01);
      @(posedge pclk) card_func_irq <= 1'b1;
      @(posedge pclk) card_func_irq <= 1'b0;
      rchk("flag set", CCR_ADDR_CARD, 8'h01);
      `CHK("irq on", irq, 1'b1)
      apb(1'b1, CCR_ADDR_CARD, 8'h00);
      rchk("flag kept", CCR_ADDR_CARD, 8'h01);
      card_func_irq <= 1'b1;
      apb(1'b1, CCR_ADDR_CARD, 8'h01);
      card_func_irq <= 1'b0;
      rchk("set beats clear", CCR_ADDR_CARD, 8'h01);
      apb(1'b1, CCR_ADDR_CARD, 8'h01);
      rchk("flag clear", CCR_ADDR_CARD, 8'h00);
      rchk("stat", CCR_ADDR_IRQ_STAT, 8'h01);
      rchk("stat clr", CCR_ADDR_IRQ_STAT, 8'h00);
      `CHK("irq off", irq, 1'b0)
      apb(1'b0, 12'hffc, 8'h00);
      `CHK("unmapped", {err, rd}, {1'b1, 32'h0})
      conclude();
   end
endmodule : ccr_regs_test
`default_nettype wire
